// ===== rtl/bst_pkg.sv
// Purpose: shared constants and types for the bit slot timer
// Assumes: 8-bit register port with a 3-bit word address
// Notes:   offsets are register indices on the plain register port
package bst_pkg;

  localparam int unsigned BST_AW       = 3;
  localparam int unsigned BST_DW       = 8;
  localparam int unsigned BST_CW       = 10;
  localparam int unsigned BST_PSEL_W   = 3;
  localparam int unsigned BST_PRE_W    = 7;

  // register offsets
  localparam logic [2:0] BST_OFS_CTRL  = 3'h0;
  localparam logic [2:0] BST_OFS_COUNT = 3'h1;
  localparam logic [2:0] BST_OFS_STAT  = 3'h2;
  localparam logic [2:0] BST_OFS_MASK  = 3'h3;
  localparam logic [2:0] BST_OFS_PWR   = 3'h4;
  localparam logic [2:0] BST_OFS_CORE  = 3'h5;
  localparam logic [2:0] BST_OFS_VEC   = 3'h6;

  // bit_timer_control fields
  localparam int unsigned BST_CTRL_HI_MSB = 7;
  localparam int unsigned BST_CTRL_HI_LSB = 6;
  localparam int unsigned BST_CTRL_DATA   = 2;
  localparam int unsigned BST_CTRL_MODE_M = 1;
  localparam int unsigned BST_CTRL_MODE_L = 0;

  // status and mask fields
  localparam int unsigned BST_ST_EMPTY = 0;
  localparam int unsigned BST_ST_EDGE  = 1;
  localparam int unsigned BST_ST_DONE  = 2;
  localparam int unsigned BST_ST_W     = 3;

  // core status global interrupt enable
  localparam int unsigned BST_CORE_GIE = 7;

  // reset values
  localparam logic [7:0] BST_CTRL_RST  = 8'h00;
  localparam logic [7:0] BST_COUNT_RST = 8'h00;
  localparam logic [2:0] BST_STAT_RST  = 3'h0;
  localparam logic [2:0] BST_MASK_RST  = 3'h0;
  localparam logic [2:0] BST_PWR_RST   = 3'h0;

  // interrupt vector word addresses
  localparam logic [7:0] BST_VEC_RESET = 8'h00;
  localparam logic [7:0] BST_VEC_DONE  = 8'h02;
  localparam logic [7:0] BST_VEC_EMPTY = 8'h04;

  typedef enum logic [1:0] {
    BST_MODE_OFF   = 2'b00,
    BST_MODE_TX    = 2'b01,
    BST_MODE_RX    = 2'b10,
    BST_MODE_TIMER = 2'b11
  } bst_mode_t;

endpackage

// ===== rtl/bst_prescaler.sv
// Purpose: core clock period tick, 2**sel system cycles per tick
// Assumes: clr_i holds the divider at its start
// Notes:   sel above the divider width saturates at the largest period
`timescale 1ns/100ps
module bst_prescaler #(
  parameter int unsigned PRE_W = bst_pkg::BST_PRE_W
) (
  input  wire logic                            clk_i,
  input  wire logic                            rst_b_i,
  input  wire logic                            clr_i,
  input  wire logic [bst_pkg::BST_PSEL_W-1:0]  sel_i,
  output logic                                 tick_o
);
  import bst_pkg::*;

  logic [PRE_W-1:0] cnt;
  logic [PRE_W-1:0] next_cnt;
  logic [PRE_W-1:0] lim;

  always_comb begin
    lim      = (PRE_W'(1) << sel_i) - PRE_W'(1);
    tick_o   = !clr_i && (cnt == lim);
    next_cnt = cnt + PRE_W'(1);
    if (clr_i || tick_o) begin
      next_cnt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule

// ===== rtl/bst_edge_det.sv
// Purpose: rising and falling edge pulses on the capture pin
// Assumes: pin is synchronous to clk_i
// Notes:   first sample after reset only primes, so no false edge
`timescale 1ns/100ps
module bst_edge_det (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);

  logic prev;
  logic primed;
  logic next_prev;
  logic next_primed;

  always_comb begin
    next_prev   = pin_i;
    next_primed = 1'b1;
    rise_o      = primed && pin_i && !prev;
    fall_o      = primed && !pin_i && prev;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      prev   <= 1'b0;
      primed <= 1'b0;
    end else begin
      prev   <= next_prev;
      primed <= next_primed;
    end
  end

endmodule

// ===== rtl/bst_bit_slot_timer.sv
// Purpose: bit slot timer keying the transmitter, pulse capture, timer
// Assumes: register port strobes one cycle, read data the next cycle
// Notes:   status bits clear on read; a same-cycle event wins
//
// Overview of operation
// [R1] each transmit slot lasts core period times (slot count plus one)
// [R2] slot count is control bits 7:6 above the eight count bits
// [R3] core period comes from the power control selection
// [R4] transmitter follows supplied bits only; software does any coding
// [R5] taking the pending bit sets flag 0, vector 0x04 when enabled
// [R6] software answers buffer empty by writing the next data bit
// [R7] counter at zero with nothing pending sets flag 2, vector 0x02
// [R8] software turns transmitter and timer off after transmit complete
// [R9] flags set identically whether or not interrupts are enabled
// [R10] receive mode counts up from zero, edge copies count to register
// [R11] rising edge sets the data bit, falling edge clears it
// [R12] generic timer never keys, interrupts after the slot count time
// [R13] no interrupt unless the global interrupt enable is set
// [R14] reset vector 000, vector 2 transmit complete, vector 4 empty
// [R15] at a boundary with a pending bit, key it and reload the counter
// [R16] flags stay until cleared, each with its own enable
// [R17] mode selects off, transmit, receive, timer; off stops and unkeys
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
module bst_bit_slot_timer
  import bst_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic [bst_pkg::BST_AW-1:0] addr_i,
  input  wire logic [bst_pkg::BST_DW-1:0] wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [bst_pkg::BST_DW-1:0] rdata_o,
  input  wire logic                     edge_capture_pin_i,
  output logic                          tx_key_o,
  output logic                          irq_o,
  output logic      [bst_pkg::BST_DW-1:0] irq_vector_o
);
  import bst_pkg::*;

  bst_mode_t              mode;
  bst_mode_t              next_mode;
  logic [1:0]             cnt_hi;
  logic [1:0]             next_cnt_hi;
  logic                   data_bit;
  logic                   next_data_bit;
  logic [7:0]             count_lo;
  logic [7:0]             next_count_lo;
  logic                   pending;
  logic                   next_pending;
  logic                   active;
  logic                   next_active;
  logic [BST_CW-1:0]      slot_cnt;
  logic [BST_CW-1:0]      next_slot_cnt;
  logic                   key;
  logic                   next_key;
  logic [BST_ST_W-1:0]    status;
  logic [BST_ST_W-1:0]    next_status;
  logic [BST_ST_W-1:0]    mask;
  logic [BST_ST_W-1:0]    next_mask;
  logic [BST_PSEL_W-1:0]  pwr_sel;
  logic [BST_PSEL_W-1:0]  next_pwr_sel;
  logic                   gie;
  logic                   next_gie;
  logic [7:0]             rdata;
  logic [7:0]             next_rdata;
  logic                   irq;
  logic                   next_irq;
  logic [7:0]             vec;
  logic [7:0]             next_vec;

  logic [BST_CW-1:0]      count_val;
  logic                   tick;
  logic                   rise;
  logic                   fall;
  logic                   ev_empty;
  logic                   ev_edge;
  logic                   ev_done;
  logic                   wr_ctrl;
  logic                   rd_stat;
  logic [BST_ST_W-1:0]    pend_irq;

  assign count_val = {cnt_hi, count_lo};  // [R2]
  assign wr_ctrl   = wr_i && (addr_i == BST_OFS_CTRL);
  assign rd_stat   = rd_i && (addr_i == BST_OFS_STAT);

  // divider restarts while off so the first slot is full length
  bst_prescaler u_pre (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .clr_i   (mode == BST_MODE_OFF),
    .sel_i   (pwr_sel),
    .tick_o  (tick)
  );

  bst_edge_det u_edge (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pin_i   (edge_capture_pin_i),
    .rise_o  (rise),
    .fall_o  (fall)
  );

  always_comb begin
    next_mode     = mode;
    next_cnt_hi   = cnt_hi;
    next_data_bit = data_bit;
    next_count_lo = count_lo;
    next_pending  = pending;
    next_active   = active;
    next_slot_cnt = slot_cnt;
    next_key      = 1'b0;
    next_mask     = mask;
    next_pwr_sel  = pwr_sel;
    next_gie      = gie;
    ev_empty      = 1'b0;
    ev_edge       = 1'b0;
    ev_done       = 1'b0;

    case (mode)
      BST_MODE_TX: begin
        next_key = key;
        if (tick) begin
          if (slot_cnt == '0) begin
            if (pending) begin
              next_key      = data_bit;  // [R4] [R15]
              next_pending  = 1'b0;
              ev_empty      = 1'b1;  // [R5]
              next_slot_cnt = count_val;  // [R1] [R15]
              next_active   = 1'b1;
            end else if (active) begin
              ev_done     = 1'b1;  // [R7]
              next_active = 1'b0;
              next_key    = 1'b0;
            end
          end else begin
            next_slot_cnt = slot_cnt - BST_CW'(1);
          end
        end
      end
      BST_MODE_RX: begin
        if (rise || fall) begin
          next_count_lo = slot_cnt[7:0];  // [R10]
          next_cnt_hi   = slot_cnt[BST_CW-1:8];
          next_data_bit = rise;  // [R11]
          ev_edge       = 1'b1;
          next_slot_cnt = '0;
        end else if (tick && (slot_cnt != '1)) begin
          next_slot_cnt = slot_cnt + BST_CW'(1);  // [R10]
        end
      end
      BST_MODE_TIMER: begin
        // periodic: interval is slot count plus one core periods
        if (tick) begin
          if (slot_cnt == '0) begin
            ev_done       = 1'b1;  // [R12]
            next_slot_cnt = count_val;
          end else begin
            next_slot_cnt = slot_cnt - BST_CW'(1);
          end
        end
      end
      default: begin
        next_slot_cnt = '0;  // [R17]
        next_pending  = 1'b0;
        next_active   = 1'b0;
      end
    endcase

    // software writes land after the timer so a new bit is never lost
    if (wr_ctrl) begin
      next_mode     = bst_mode_t'(wdata_i[BST_CTRL_MODE_M:BST_CTRL_MODE_L]);
      next_cnt_hi   = wdata_i[BST_CTRL_HI_MSB:BST_CTRL_HI_LSB];
      next_data_bit = wdata_i[BST_CTRL_DATA];
      if (next_mode == BST_MODE_TX) begin
        next_pending = 1'b1;  // [R6]
      end
      if (next_mode != mode) begin
        next_active   = 1'b0;
        next_pending  = (next_mode == BST_MODE_TX);
        next_slot_cnt = (next_mode == BST_MODE_TIMER)
                        ? {wdata_i[BST_CTRL_HI_MSB:BST_CTRL_HI_LSB],
                           next_count_lo}
                        : '0;
      end
    end
    if (wr_i && (addr_i == BST_OFS_COUNT)) begin
      next_count_lo = wdata_i;
    end
    if (wr_i && (addr_i == BST_OFS_MASK)) begin
      next_mask = wdata_i[BST_ST_W-1:0];  // [R16]
    end
    if (wr_i && (addr_i == BST_OFS_PWR)) begin
      next_pwr_sel = wdata_i[BST_PSEL_W-1:0];  // [R3]
    end
    if (wr_i && (addr_i == BST_OFS_CORE)) begin
      next_gie = wdata_i[BST_CORE_GIE];
    end
  end

  // flags: read clears, an event in the same cycle wins
  always_comb begin
    next_status = status;
    if (rd_stat) begin
      next_status = '0;
    end
    next_status[BST_ST_EMPTY] = next_status[BST_ST_EMPTY] | ev_empty;  // [R9]
    next_status[BST_ST_EDGE]  = next_status[BST_ST_EDGE] | ev_edge;
    next_status[BST_ST_DONE]  = next_status[BST_ST_DONE] | ev_done;  // [R16]
    pend_irq = next_status & next_mask;
    next_irq = next_gie && (pend_irq != '0);  // [R13]
    // lower vector address is served first
    if (!next_irq) begin
      next_vec = BST_VEC_RESET;  // [R14]
    end else if (pend_irq[BST_ST_DONE]) begin
      next_vec = BST_VEC_DONE;  // [R7] [R14]
    end else if (pend_irq[BST_ST_EMPTY]) begin
      next_vec = BST_VEC_EMPTY;  // [R5] [R14]
    end else begin
      next_vec = BST_VEC_RESET;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        BST_OFS_CTRL:  next_rdata = {cnt_hi, 3'h0, data_bit, mode};
        BST_OFS_COUNT: next_rdata = count_lo;
        BST_OFS_STAT:  next_rdata = {5'h00, status};
        BST_OFS_MASK:  next_rdata = {5'h00, mask};
        BST_OFS_PWR:   next_rdata = {5'h00, pwr_sel};
        BST_OFS_CORE:  next_rdata = {gie, 7'h00};
        BST_OFS_VEC:   next_rdata = vec;
        default:       next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mode     <= BST_MODE_OFF;
      cnt_hi   <= BST_CTRL_RST[BST_CTRL_HI_MSB:BST_CTRL_HI_LSB];
      data_bit <= BST_CTRL_RST[BST_CTRL_DATA];
      count_lo <= BST_COUNT_RST;
      pending  <= 1'b0;
      active   <= 1'b0;
      slot_cnt <= '0;
      key      <= 1'b0;
      status   <= BST_STAT_RST;
      mask     <= BST_MASK_RST;
      pwr_sel  <= BST_PWR_RST;
      gie      <= 1'b0;
      rdata    <= 8'h00;
      irq      <= 1'b0;
      vec      <= BST_VEC_RESET;
    end else begin
      mode     <= next_mode;
      cnt_hi   <= next_cnt_hi;
      data_bit <= next_data_bit;
      count_lo <= next_count_lo;
      pending  <= next_pending;
      active   <= next_active;
      slot_cnt <= next_slot_cnt;
      key      <= next_key;
      status   <= next_status;
      mask     <= next_mask;
      pwr_sel  <= next_pwr_sel;
      gie      <= next_gie;
      rdata    <= next_rdata;
      irq      <= next_irq;
      vec      <= next_vec;
    end
  end

  assign rdata_o      = rdata;
  assign tx_key_o     = key;
  assign irq_o        = irq;
  assign irq_vector_o = vec;

  AST_SLOT_RELOAD: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R1]
    (mode == BST_MODE_TX) && tick && (slot_cnt == '0) && pending && !wr_i
    |=> (slot_cnt == $past(count_val)) && (tx_key_o == $past(data_bit)))
    else $error("slot counter not reloaded with the bit keyed");

  AST_COUNT_FORM: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R2]
    wr_ctrl && (mode == BST_MODE_OFF) && !rise && !fall
    |=> count_val[BST_CW-1:8] == $past(wdata_i[7:6]))
    else $error("slot count high bits not from control");

  AST_PRESCALE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R3]
    tick && (pwr_sel == 3'h1) && !wr_i ##1 !wr_i |-> !tick ##1 tick)
    else $error("core period tick spacing wrong");

  AST_KEY_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R15]
    (mode == BST_MODE_TX) && !tick && !wr_i |=> $stable(tx_key_o))
    else $error("transmitter state changed inside a slot");

  AST_EMPTY_FLAG: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R5]
    ev_empty && !wr_ctrl |=> status[BST_ST_EMPTY] && !pending)
    else $error("buffer empty flag not set");

  AST_DONE_FLAG: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R7]
    (mode == BST_MODE_TX) && tick && (slot_cnt == '0) && !pending && active
    |=> status[BST_ST_DONE] && !tx_key_o)
    else $error("transmit complete flag not set");

  AST_RX_CAPTURE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R11]
    (mode == BST_MODE_RX) && (rise || fall) && !wr_i
    |=> (data_bit == $past(rise)) && (count_val == $past(slot_cnt))
        && (slot_cnt == '0))
    else $error("edge capture wrong");

  AST_NO_KEY: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R12]
    (mode != BST_MODE_TX) |=> !tx_key_o)
    else $error("transmitter keyed outside transmit mode");

  AST_GIE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R13]
    !gie |-> !irq_o)
    else $error("interrupt without global enable");

  AST_VECTOR: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R14]
    irq_o && status[BST_ST_DONE] && mask[BST_ST_DONE]
    |-> irq_vector_o == BST_VEC_DONE)
    else $error("wrong vector for transmit complete");

  AST_STICKY: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R16]
    status[BST_ST_EMPTY] && !rd_stat |=> status[BST_ST_EMPTY])
    else $error("flag cleared without a status read");

endmodule

// ===== dv/bst_far_side.sv
// Purpose: far side model, transmitter keying watcher and receiver output
// Assumes: receiver output is a clean level synchronous to clk_i
// Notes:   pin idles low like a quiet receiver; width kept until the next burst ends
`timescale 1ns/100ps
module bst_far_side (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       tx_key_i,
  input  wire logic       go_i,
  input  wire logic [9:0] len_i,
  output logic            pin_o,
  output logic [9:0]      key_width_o
);
  logic [9:0] run;
  logic [9:0] left;

  // length of the last keyed burst, taken when the carrier drops
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      run <= 10'h000;
      key_width_o <= 10'h000;
    end else if (tx_key_i) begin
      run <= run + 10'h001;
    end else if (run != 10'h000) begin
      key_width_o <= run;
      run <= 10'h000;
    end
  end

  // one high pulse of len_i cycles per go_i
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      left <= 10'h000;
    end else if (go_i) begin
      left <= len_i;
    end else if (left != 10'h000) begin
      left <= left - 10'h001;
    end
  end
  assign pin_o = (left != 10'h000);
endmodule

// ===== dv/bst_bit_slot_timer_tb.sv
// Purpose: self-checking bench for the bit slot timer
// Assumes: register port answers one cycle after the read strobe
// Notes:   capture and timer latencies checked with a small margin
`timescale 1ns/100ps
module bst_bit_slot_timer_tb;
  import bst_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic        pin;
  logic        key;
  logic        irq;
  logic [7:0]  vec;
  logic        go = 1'b0;
  logic [9:0]  len = 10'h000;
  logic [9:0]  kw;
  logic [7:0]  rv;
  logic        keyed;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          n;
  int          w;
  // rows: hi, lo, sel, mask, gie
  logic [7:0]  tbl [4][5] = '{'{8'h0, 8'h2, 8'h0, 8'h5, 8'h1},
                             '{8'h0, 8'h2, 8'h1, 8'h1, 8'h1},
                             '{8'h1, 8'h1, 8'h0, 8'h0, 8'h1},
                             '{8'h0, 8'h0, 8'h2, 8'h5, 8'h0}};

  bst_bit_slot_timer u_dut (
    .clk_i              (clk_i),
    .rst_b_i            (rst_b_i),
    .addr_i             (addr),
    .wdata_i            (wdata),
    .wr_i               (wr),
    .rd_i               (rd),
    .rdata_o            (rdata),
    .edge_capture_pin_i (pin),
    .tx_key_o           (key),
    .irq_o              (irq),
    .irq_vector_o       (vec)
  );

  bst_far_side u_far (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .tx_key_i    (key),
    .go_i        (go),
    .len_i       (len),
    .pin_o       (pin),
    .key_width_o (kw)
  );

  always #25 clk_i = ~clk_i;

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // hang guard, well above the under one thousand cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // bounded wait for the interrupt, noting any keying meanwhile
  task automatic wait_irq();
    n = 0;
    keyed = 1'b0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      #1;
      keyed = keyed | key;
      n++;
    end
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // reset values, unmapped and read-only places
    for (int a = 0; a < 8; a++) begin
      if (a != 5) begin
        rd_reg(a[2:0], rv);
        chk(rv, 10'h000);
      end
    end
    wr_reg(3'h7, 8'hFF);
    rd_reg(3'h7, rv);
    chk(rv, 10'h000);
    wr_reg(BST_OFS_STAT, 8'hFF);
    rd_reg(BST_OFS_STAT, rv);
    chk(rv, 10'h000);
    wr_reg(BST_OFS_MASK, 8'hFF);
    rd_reg(BST_OFS_MASK, rv);
    chk(rv, 10'h007);
    // one keyed bit per row: slot width, flags, gating of the request
    for (int i = 0; i < 4; i++) begin
      w = ({tbl[i][0][1:0], tbl[i][1]} + 1) << tbl[i][2];
      wr_reg(BST_OFS_PWR, tbl[i][2]);
      wr_reg(BST_OFS_MASK, tbl[i][3]);
      wr_reg(BST_OFS_CORE, {tbl[i][4][0], 7'h00});
      wr_reg(BST_OFS_COUNT, tbl[i][1]);
      wr_reg(BST_OFS_CTRL, {tbl[i][0][1:0], 6'h05});
      repeat (w + 40) @(posedge clk_i);
      #1;
      chk(kw, w[9:0]);
      chk(irq, tbl[i][4][0] && tbl[i][3] != 8'h0);
      chk(vec, !tbl[i][4][0] ? 8'h00 : tbl[i][3][2] ? 8'h02 :
               tbl[i][3][0] ? 8'h04 : 8'h00);
      rd_reg(BST_OFS_STAT, rv);
      chk(rv, 10'h005);
      chk(irq, 1'b0);
      wr_reg(BST_OFS_CTRL, 8'h00);
    end
    // receive: one pulse of 20 cycles from the receiver
    wr_reg(BST_OFS_PWR, 8'h00);
    wr_reg(BST_OFS_CTRL, 8'h02);
    @(posedge clk_i);
    go <= 1'b1;
    len <= 10'd20;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd_reg(BST_OFS_CTRL, rv);
    chk(rv[2:0], 10'h006);
    repeat (30) @(posedge clk_i);
    rd_reg(BST_OFS_CTRL, rv);
    chk(rv[2:0], 10'h002);
    rd_reg(BST_OFS_COUNT, rv);
    chk(rv >= 8'd18 && rv <= 8'd22, 10'h001);
    rd_reg(BST_OFS_STAT, rv);
    chk(rv, 10'h002);
    // generic timer: period of count plus one ticks, carrier stays off
    wr_reg(BST_OFS_MASK, 8'h04);
    wr_reg(BST_OFS_CORE, 8'h80);
    wr_reg(BST_OFS_COUNT, 8'h03);
    wr_reg(BST_OFS_CTRL, 8'h03);
    wait_irq();
    chk(n >= 2 && n <= 8, 10'h001);
    chk(keyed, 1'b0);
    chk(vec, 10'h002);
    wr_reg(BST_OFS_CTRL, 8'h00);
    rd_reg(BST_OFS_STAT, rv);
    // two keyed bits: next bit written once flag 0 is up, carrier unbroken
    wr_reg(BST_OFS_COUNT, 8'h09);
    wr_reg(BST_OFS_CTRL, 8'h05);
    wr_reg(BST_OFS_CTRL, 8'h05);
    repeat (30) @(posedge clk_i);
    #1;
    chk(kw, 10'd20);
    chk(vec, 10'h002);
    rd_reg(BST_OFS_STAT, rv);
    chk(rv, 10'h005);
    wr_reg(BST_OFS_CTRL, 8'h00);
    repeat (20) @(posedge clk_i);
    #1;
    chk(irq, 1'b0);
    chk(key, 1'b0);
    wrap_up();
  end
endmodule
